// File: verilog/smmg_gate.v
// Mode tracking, command gating and output path control
`timescale 1ns/1ps
`include "smmg_defs.vh"
module smmg_gate #(
  parameter AUTH_WIDTH = 256
) (
  input wire clock,
  input wire rst_n,
  input wire boot_done,
  input wire fw_integrity_fail,
  input wire selftest_fail,
  input wire selftest_active,
  input wire upgrade_cmd_error,
  input wire legacy_set,
  input wire cmd_valid,
  input wire [3:0] cmd_class,
  input wire [15:0] cmd_param_size,
  input wire [15:0] cmd_expected_size,
  input wire [15:0] operator_id,
  input wire auth_required,
  input wire auth_is_user,
  input wire user_auth_attribute,
  input wire policy_session,
  input wire policy_cc_duplicate,
  input wire [AUTH_WIDTH-1:0] auth_reference,
  input wire [AUTH_WIDTH-1:0] auth_computed,
  input wire [8:0] auth_length,
  input wire exec_done,
  input wire exec_ok,
  input wire exec_has_data,
  input wire decrypt_done,
  input wire decrypt_ok,
  input wire physical_presence_input,
  output reg cmd_ready,
  output reg dispatch,
  output reg [3:0] dispatch_class,
  output reg start_decrypt,
  output reg fw_reload,
  output reg rsp_valid,
  output reg [11:0] rsp_code,
  output reg rsp_has_data,
  output reg data_path_enable,
  output reg status_path_enable,
  output reg internal_reset_n,
  output reg host_interrupt_request,
  output reg [1:0] mode
);
  // Controller states
  localparam ST_IDLE = 3'h0;
  localparam ST_AUTH = 3'h1;
  localparam ST_DECRYPT = 3'h2;
  localparam ST_EXEC = 3'h3;
  localparam ST_RESP = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] cur_class;
  reg [15:0] cur_operator;
  reg key_op;
  reg [3:0] rst_count;
  reg [1:0] pp_sync;
  reg [1:0] next_mode;
  reg permitted;
  reg auth_start;
  wire auth_done;
  wire auth_match;
  wire size_ok;
  wire auth_len_ok;
  wire dup_ok;
  wire data_inhibit;
  ////////////////////////////////////////////////////////////////
  // Authorization comparator
  smmg_auth_compare #(
    .WIDTH(AUTH_WIDTH)
  ) u_cmp (
    .clock(clock),
    .rst_n(rst_n),
    .start(auth_start),
    .reference(auth_reference),
    .computed(auth_computed),
    .length_bits(auth_length),
    .done(auth_done),
    .match(auth_match)
  );
  ////////////////////////////////////////////////////////////////
  // Static command checks
  assign size_ok = (cmd_param_size == cmd_expected_size);
  assign auth_len_ok = !auth_is_user || (user_auth_attribute &&
    (auth_length == `SMMG_AUTH_SHORT_BITS || auth_length == `SMMG_AUTH_LONG_BITS));
  assign dup_ok = (cur_class != `SMMG_CMD_DUPLICATE) || (policy_session && policy_cc_duplicate);
  assign data_inhibit = selftest_active || (mode != `SMMG_MODE_NORMAL) || key_op;
  ////////////////////////////////////////////////////////////////
  // Mode permission table
  always @* begin
    permitted = 1'b0;
    case (mode)
      `SMMG_MODE_NORMAL: begin
        permitted = 1'b1;
      end
      `SMMG_MODE_FAILURE: begin
        permitted = (cmd_class == `SMMG_CMD_GET_CAP) || (cmd_class == `SMMG_CMD_TEST_RESULT) ||
          (legacy_set && cmd_class == `SMMG_CMD_STARTUP);
      end
      `SMMG_MODE_REDUCED: begin
        permitted = (cmd_class == `SMMG_CMD_UPG_START) || (cmd_class == `SMMG_CMD_UPG_DATA) ||
          (cmd_class == `SMMG_CMD_GET_CAP) || (cmd_class == `SMMG_CMD_TEST_RESULT) ||
          (cmd_class == `SMMG_CMD_SELF_TEST);
      end
      default: begin
        permitted = 1'b0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Mode transitions; shutdown is terminal until rst_n is asserted
  always @* begin
    next_mode = mode;
    case (mode)
      `SMMG_MODE_SHUTDOWN: begin
        next_mode = `SMMG_MODE_SHUTDOWN;
      end
      default: begin
        if (fw_integrity_fail && !boot_done)
          next_mode = `SMMG_MODE_SHUTDOWN;
        else if (selftest_fail)
          next_mode = `SMMG_MODE_FAILURE;
        else if (mode == `SMMG_MODE_REDUCED && state == ST_EXEC && exec_done && exec_ok &&
                 cur_class == `SMMG_CMD_UPG_START)
          next_mode = `SMMG_MODE_NORMAL;
        else if (mode == `SMMG_MODE_NORMAL && upgrade_cmd_error)
          next_mode = `SMMG_MODE_REDUCED;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Next controller state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_valid && mode != `SMMG_MODE_SHUTDOWN) begin
          if (!permitted || !size_ok)
            next_state = ST_RESP;
          else if (auth_required)
            next_state = ST_AUTH;
          else if (cmd_class == `SMMG_CMD_PLAINTEXT)
            next_state = ST_DECRYPT;
          else
            next_state = ST_EXEC;
        end
      end
      ST_AUTH: begin
        // Wait out the full compare even on early refusal: comparator stays in step, timing leaks nothing
        if (auth_done)
          next_state = (!auth_match || !auth_len_ok || !dup_ok) ? ST_RESP :
            (cur_class == `SMMG_CMD_PLAINTEXT ? ST_DECRYPT : ST_EXEC);
      end
      ST_DECRYPT: begin
        if (decrypt_done)
          next_state = decrypt_ok ? ST_EXEC : ST_RESP;
      end
      ST_EXEC: begin
        if (exec_done)
          next_state = ST_RESP;
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Sequential control; one command owns the gate until it answers
  always @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      mode <= `SMMG_MODE_NORMAL;
      cur_class <= `SMMG_CMD_OTHER;
      cur_operator <= 16'h0000;
      key_op <= 1'b0;
      rst_count <= 4'h0;
      pp_sync <= 2'h0;
      auth_start <= 1'b0;
      cmd_ready <= 1'b0;
      dispatch <= 1'b0;
      dispatch_class <= `SMMG_CMD_OTHER;
      start_decrypt <= 1'b0;
      fw_reload <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_code <= `SMMG_RC_SUCCESS;
      rsp_has_data <= 1'b0;
      data_path_enable <= 1'b0;
      status_path_enable <= 1'b0;
      internal_reset_n <= 1'b1;
      host_interrupt_request <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      pp_sync <= {pp_sync[0], physical_presence_input}; // Pin synchroniser, not otherwise used
      auth_start <= 1'b0;
      dispatch <= 1'b0;
      start_decrypt <= 1'b0;
      fw_reload <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_has_data <= 1'b0;
      data_path_enable <= 1'b0;
      status_path_enable <= (next_mode != `SMMG_MODE_SHUTDOWN);
      cmd_ready <= (next_state == ST_IDLE) && (next_mode != `SMMG_MODE_SHUTDOWN);
      host_interrupt_request <= 1'b0;
      // Shutdown: pulse internal reset forever
      if (mode == `SMMG_MODE_SHUTDOWN) begin
        rst_count <= rst_count + 4'h1;
        internal_reset_n <= (rst_count != `SMMG_SHUTDOWN_PULSE);
      end else begin
        internal_reset_n <= 1'b1;
      end
      // Capture command on acceptance
      if (state == ST_IDLE && cmd_valid && mode != `SMMG_MODE_SHUTDOWN) begin
        cur_class <= cmd_class;
        cur_operator <= operator_id;
        key_op <= (cmd_class == `SMMG_CMD_KEYGEN) || (cmd_class == `SMMG_CMD_ZEROIZE);
        if (!permitted) begin
          rsp_code <= (mode == `SMMG_MODE_REDUCED) ? `SMMG_RC_COMMAND_CODE :
            (legacy_set ? `SMMG_RC_LEGACY_FAILED : `SMMG_RC_FAILURE);
        end else if (!size_ok) begin
          rsp_code <= `SMMG_RC_BAD_SIZE;
        end else begin
          rsp_code <= `SMMG_RC_SUCCESS;
          auth_start <= auth_required;
          start_decrypt <= !auth_required && cmd_class == `SMMG_CMD_PLAINTEXT;
          dispatch <= !auth_required && cmd_class != `SMMG_CMD_PLAINTEXT;
          dispatch_class <= cmd_class;
        end
      end
      // Authorization outcome
      if (state == ST_AUTH && auth_done) begin
        if (!auth_len_ok || !dup_ok || !auth_match) begin
          rsp_code <= `SMMG_RC_AUTH_FAIL;
        end else begin
          start_decrypt <= (cur_class == `SMMG_CMD_PLAINTEXT);
          dispatch <= (cur_class != `SMMG_CMD_PLAINTEXT);
        end
      end
      // Decrypt outcome gates plaintext release
      if (state == ST_DECRYPT && decrypt_done) begin
        if (decrypt_ok)
          dispatch <= 1'b1;
        else
          rsp_code <= `SMMG_RC_AUTH_FAIL;
      end
      // Execution result
      if (state == ST_EXEC && exec_done) begin
        rsp_code <= exec_ok ? `SMMG_RC_SUCCESS : `SMMG_RC_FAILURE;
        rsp_has_data <= exec_ok && exec_has_data && !data_inhibit;
        if (exec_ok && mode == `SMMG_MODE_REDUCED && cur_class == `SMMG_CMD_UPG_START)
          fw_reload <= 1'b1;
      end
      // Response: status always, data only when carried and allowed
      if (state == ST_RESP) begin
        rsp_valid <= 1'b1;
        rsp_has_data <= rsp_has_data;
        data_path_enable <= rsp_has_data && !data_inhibit;
        host_interrupt_request <= 1'b1;
        key_op <= 1'b0;
      end
    end
  end
endmodule

// File: verilog/smmg_defs.vh
// Constants for the secure module mode gate
`ifndef SMMG_DEFS_VH
`define SMMG_DEFS_VH
// Operating modes
`define SMMG_MODE_NORMAL 2'h0
`define SMMG_MODE_FAILURE 2'h1
`define SMMG_MODE_REDUCED 2'h2
`define SMMG_MODE_SHUTDOWN 2'h3
// Command classes decoded upstream
`define SMMG_CMD_OTHER 4'h0
`define SMMG_CMD_STARTUP 4'h1
`define SMMG_CMD_GET_CAP 4'h2
`define SMMG_CMD_TEST_RESULT 4'h3
`define SMMG_CMD_UPG_START 4'h4
`define SMMG_CMD_UPG_DATA 4'h5
`define SMMG_CMD_SELF_TEST 4'h6
`define SMMG_CMD_DUPLICATE 4'h7
`define SMMG_CMD_PLAINTEXT 4'h8
`define SMMG_CMD_KEYGEN 4'h9
`define SMMG_CMD_ZEROIZE 4'hA
// Error codes
`define SMMG_RC_SUCCESS 12'h000
`define SMMG_RC_LEGACY_FAILED 12'h01C
`define SMMG_RC_FAILURE 12'h101
`define SMMG_RC_COMMAND_CODE 12'h143
`define SMMG_RC_AUTH_FAIL 12'h18E
`define SMMG_RC_BAD_SIZE 12'h195
// Authorization widths in bits
`define SMMG_AUTH_SHORT_BITS 9'd160
`define SMMG_AUTH_LONG_BITS 9'd256
// Counter value at which the one-cycle shutdown reset pulse fires
`define SMMG_SHUTDOWN_PULSE 4'hF
`endif

// File: verilog/smmg_auth_compare.v
// Serial comparator of reference and computed authorization values
`timescale 1ns/1ps
module smmg_auth_compare #(
  parameter WIDTH = 256
) (
  input wire clock,
  input wire rst_n,
  input wire start,
  input wire [WIDTH-1:0] reference,
  input wire [WIDTH-1:0] computed,
  input wire [8:0] length_bits,
  output reg done,
  output reg match
);
  // Index of the last bit walked; the counter is nine bits wide
  localparam [8:0] LAST_IDX = WIDTH - 1;
  reg [WIDTH-1:0] diff_mask;
  reg busy;
  reg [8:0] idx;
  wire [WIDTH-1:0] diff;
  genvar g;
  ////////////////////////////////////////////////////////////////
  // Bitwise difference limited to the active length
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : gen_diff
      assign diff[g] = (g < length_bits) ? (reference[g] ^ computed[g]) : 1'b0;
    end
  endgenerate
  ////////////////////////////////////////////////////////////////
  // Walk the mask one bit per cycle; constant time so timing leaks nothing
  always @(posedge clock) begin
    if (!rst_n) begin
      diff_mask <= {WIDTH{1'b0}};
      busy <= 1'b0;
      idx <= 9'h000;
      done <= 1'b0;
      match <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        diff_mask <= diff;
        busy <= 1'b1;
        idx <= 9'h000;
        match <= 1'b1;
      end else if (busy) begin
        if (diff_mask[idx[7:0]])
          match <= 1'b0; // Any differing bit breaks equality
        if (idx == LAST_IDX) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        idx <= idx + 9'h001;
      end
    end
  end
endmodule

// File: bench/smmg_gate_asserts.sv
// Port assertions for the mode gate
`timescale 1ns/1ps
`include "smmg_defs.vh"
module smmg_gate_asserts #(
  parameter AUTH_WIDTH = 256
) (
  input wire clock,
  input wire rst_n,
  input wire legacy_set,
  input wire cmd_valid,
  input wire [3:0] cmd_class,
  input wire cmd_ready,
  input wire dispatch,
  input wire rsp_valid,
  input wire [11:0] rsp_code,
  input wire rsp_has_data,
  input wire data_path_enable,
  input wire status_path_enable,
  input wire internal_reset_n,
  input wire [1:0] mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Unknown-class command taken at this edge
  wire take = cmd_ready && cmd_valid && cmd_class == `SMMG_CMD_OTHER;
  a_fail_legacy_code: assert property (take && mode == `SMMG_MODE_FAILURE && legacy_set
    |-> ##1 !dispatch ##1 rsp_valid && rsp_code == `SMMG_RC_LEGACY_FAILED) else $error("legacy refusal wrong");
  a_fail_new_code: assert property (take && mode == `SMMG_MODE_FAILURE && !legacy_set
    |-> ##1 !dispatch ##1 rsp_valid && rsp_code == `SMMG_RC_FAILURE) else $error("failure refusal wrong");
  a_reduced_code: assert property (take && mode == `SMMG_MODE_REDUCED
    |-> ##1 !dispatch ##1 rsp_valid && rsp_code == `SMMG_RC_COMMAND_CODE) else $error("reduced refusal wrong");
  a_refusal_no_data: assert property (rsp_valid && rsp_code != `SMMG_RC_SUCCESS |-> !data_path_enable)
    else $error("refusal carried data");
  // Data leaves only with a payload response in normal mode
  a_data_with_payload: assert property (data_path_enable |-> rsp_valid && $past(rsp_has_data) && mode == 2'h0)
    else $error("data path opened wrongly");
  a_shutdown_silent: assert property (mode == `SMMG_MODE_SHUTDOWN |-> !cmd_ready && !dispatch && !status_path_enable)
    else $error("shutdown not silent");
  a_shutdown_sticky: assert property (mode == `SMMG_MODE_SHUTDOWN |=> mode == `SMMG_MODE_SHUTDOWN)
    else $error("shutdown left");
  a_reset_loop: assert property (mode == `SMMG_MODE_SHUTDOWN |-> ##[0:16] !internal_reset_n)
    else $error("reset loop stalled");
endmodule

// File: bench/smmg_exec_model.sv
// Behavioural executor and decrypt engine behind the gate
`timescale 1ns/1ps
module smmg_exec_model (
  input wire clock,
  input wire dispatch,
  input wire start_decrypt,
  input wire slow,
  input wire with_data,
  output reg exec_done = 1'b0,
  output reg exec_ok = 1'b0,
  output reg exec_has_data = 1'b0,
  output reg decrypt_done = 1'b0,
  output reg decrypt_ok = 1'b0
);
  reg [5:0] cnt = 6'h00;
  reg [1:0] dcnt = 2'h0;
  // Result lines toggle outside the done cycle so stale values never pass
  always @(posedge clock) begin
    exec_done <= 1'b0;
    decrypt_done <= 1'b0;
    if (dispatch)
      cnt <= slow ? 6'h28 : 6'h03;
    else if (cnt != 6'h00)
      cnt <= cnt - 6'h01;
    if (cnt == 6'h01) begin
      exec_done <= 1'b1;
      exec_ok <= 1'b1;
      exec_has_data <= with_data;
    end else begin
      exec_ok <= ~exec_ok;
      exec_has_data <= ~exec_has_data;
    end
    dcnt <= start_decrypt ? 2'h2 : dcnt - (dcnt != 2'h0);
    decrypt_ok <= dcnt == 2'h1 ? 1'b1 : ~decrypt_ok;
    if (dcnt == 2'h1)
      decrypt_done <= 1'b1;
  end
endmodule

// File: bench/tb_smmg_gate.sv
// Self-checking bench for the mode gate
`timescale 1ns/1ps
`include "smmg_defs.vh"
module tb_smmg_gate;
  reg clock = 0, rst_n = 0, boot_done = 0, fw_integrity_fail = 0, selftest_fail = 0, selftest_active = 0;
  reg upgrade_cmd_error = 0, legacy_set = 0, cmd_valid = 0, auth_required = 0, slow = 0;
  reg [3:0] cmd_class = 4'h0;
  reg [255:0] auth_computed = 256'h0;
  reg [15:0] cmd_param_size = 16'h000A;
  reg [8:0] auth_length = 9'h100;
  reg user_auth_attribute = 1, policy_session = 0, policy_cc_duplicate = 0, with_data = 1;
  reg saw_disp, saw_data, saw_reload;
  reg [11:0] code;
  reg [19:0] r;
  reg [19:0] rows [0:11];
  integer fails = 0, n_checks = 0, i, k, left;
  wire cmd_ready, dispatch, start_decrypt, fw_reload, rsp_valid, rsp_has_data, data_path_enable;
  wire status_path_enable, internal_reset_n, host_interrupt_request, exec_done, exec_ok, exec_has_data;
  wire decrypt_done, decrypt_ok;
  wire [3:0] dispatch_class;
  wire [11:0] rsp_code;
  wire [1:0] mode;
  always #2 clock = ~clock;
  smmg_gate #(.AUTH_WIDTH(256)) smmg_gate_inst (.clock, .rst_n, .boot_done, .fw_integrity_fail, .selftest_fail,
    .selftest_active, .upgrade_cmd_error, .legacy_set, .cmd_valid, .cmd_class, .cmd_param_size,
    .cmd_expected_size(16'h000A), .operator_id(16'h0001), .auth_required, .auth_is_user(1'b1),
    .user_auth_attribute, .policy_session, .policy_cc_duplicate, .auth_reference(256'h0),
    .auth_computed, .auth_length, .exec_done, .exec_ok, .exec_has_data, .decrypt_done, .decrypt_ok,
    .physical_presence_input(1'b0), .cmd_ready, .dispatch, .dispatch_class, .start_decrypt, .fw_reload,
    .rsp_valid, .rsp_code, .rsp_has_data, .data_path_enable, .status_path_enable, .internal_reset_n,
    .host_interrupt_request, .mode);
  smmg_exec_model smmg_exec_model_inst (.clock, .dispatch, .start_decrypt, .slow, .with_data,
    .exec_done, .exec_ok, .exec_has_data, .decrypt_done, .decrypt_ok);
  task check(input [95:0] name, input [11:0] exp, input [11:0] got); begin
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected %0s expected %h seen %h", name, exp, got);
    end
  end endtask
  task conclude; begin
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end endtask
  task do_reset; begin
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  end endtask
  // Mode entry by a one-cycle event pulse
  task enter(input [1:0] m); begin
    selftest_fail <= m == 2'h1;
    upgrade_cmd_error <= m == 2'h2;
    @(posedge clock);
    selftest_fail <= 1'b0;
    upgrade_cmd_error <= 1'b0;
    repeat (3) @(posedge clock);
    check("mode", {10'h000, m}, {10'h000, mode});
  end endtask
  // One command, then watch a few cycles past the response
  task run_cmd(input [3:0] cls); begin
    k = 0;
    while (cmd_ready !== 1'b1 && k < 50) begin
      @(posedge clock);
      k = k + 1;
    end
    cmd_valid <= 1'b1;
    cmd_class <= cls;
    @(posedge clock);
    cmd_valid <= 1'b0;
    saw_disp = 0;
    saw_data = 0;
    saw_reload = 0;
    code = 12'hFFF;
    left = 4;
    while (left > 0 && k < 800) begin
      @(posedge clock);
      k = k + 1;
      saw_disp = saw_disp | (dispatch === 1'b1);
      saw_data = saw_data | (data_path_enable === 1'b1);
      saw_reload = saw_reload | (fw_reload === 1'b1);
      if (rsp_valid === 1'b1)
        code = rsp_code;
      if (code !== 12'hFFF)
        left = left - 1;
    end
    if (left > 0) begin
      fails = fails + 1;
      conclude;
    end
  end endtask
  initial begin
    // Row: mode, legacy, class, dispatched, response code
    rows[0] = 20'h01000;
    rows[1] = 20'h63000;
    rows[2] = 20'h6001C;
    rows[3] = 20'h42101;
    rows[4] = 20'h45000;
    rows[5] = 20'h47000;
    rows[6] = 20'h4C101;
    rows[7] = 20'h8B000;
    rows[8] = 20'h8D000;
    rows[9] = 20'h80143;
    rows[10] = 20'hA2143;
    rows[11] = 20'h85000;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    fw_integrity_fail <= 1'b1;
    @(posedge clock);
    fw_integrity_fail <= 1'b0;
    boot_done <= 1'b1;
    cmd_valid <= 1'b1;
    repeat (3) @(posedge clock);
    check("shutdown", 12'h003, {10'h000, mode});
    k = 0;
    repeat (40) @(posedge clock) k = k + (internal_reset_n === 1'b0);
    check("resets", 12'h001, {11'h000, k >= 2});
    cmd_valid <= 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      r = rows[i];
      do_reset;
      legacy_set <= r[17];
      enter(r[19:18]);
      run_cmd(r[16:13]);
      check("dispatch", {11'h000, r[12]}, {11'h000, saw_disp});
      check("code", r[11:0], code);
      check("data", {11'h000, r[12] && r[19:18] == 2'h0}, {11'h000, saw_data});
    end
    // Self-test running: response arrives but data stays inside
    do_reset;
    legacy_set <= 1'b0;
    selftest_active <= 1'b1;
    run_cmd(`SMMG_CMD_OTHER);
    check("st_data", 12'h000, {11'h000, saw_data});
    selftest_active <= 1'b0;
    // Slow executor, wrong then right authorization
    slow <= 1'b1;
    auth_required <= 1'b1;
    auth_computed <= 256'h1;
    run_cmd(`SMMG_CMD_OTHER);
    check("auth_bad", `SMMG_RC_AUTH_FAIL, code);
    check("auth_disp", 12'h000, {11'h000, saw_disp});
    auth_computed <= 256'h0;
    run_cmd(`SMMG_CMD_OTHER);
    check("auth_ok", 12'h001, {11'h000, saw_disp});
    slow <= 1'b0;
    // Short secret accepted, odd length and missing attribute refused
    auth_length <= 9'h0A0;
    run_cmd(`SMMG_CMD_OTHER);
    check("auth_160", 12'h001, {11'h000, saw_disp});
    auth_length <= 9'h080;
    run_cmd(`SMMG_CMD_OTHER);
    check("auth_len", `SMMG_RC_AUTH_FAIL, code);
    auth_length <= 9'h100;
    user_auth_attribute <= 1'b0;
    run_cmd(`SMMG_CMD_OTHER);
    check("auth_attr", `SMMG_RC_AUTH_FAIL, code);
    user_auth_attribute <= 1'b1;
    // Duplication only through a policy naming the duplicate command
    run_cmd(`SMMG_CMD_DUPLICATE);
    check("dup_bad", `SMMG_RC_AUTH_FAIL, code);
    policy_session <= 1'b1;
    policy_cc_duplicate <= 1'b1;
    run_cmd(`SMMG_CMD_DUPLICATE);
    check("dup_ok", 12'h001, {11'h000, saw_disp});
    policy_session <= 1'b0;
    policy_cc_duplicate <= 1'b0;
    auth_required <= 1'b0;
    // Malformed parameter size refused without dispatch
    cmd_param_size <= 16'h000B;
    run_cmd(`SMMG_CMD_OTHER);
    check("size", `SMMG_RC_BAD_SIZE, code);
    check("size_disp", 12'h000, {11'h000, saw_disp});
    cmd_param_size <= 16'h000A;
    // Key generation keeps the data path shut, status still answers
    run_cmd(`SMMG_CMD_KEYGEN);
    check("key_data", 12'h000, {11'h000, saw_data});
    check("key_code", `SMMG_RC_SUCCESS, code);
    // Response without payload opens no data path
    with_data <= 1'b0;
    run_cmd(`SMMG_CMD_OTHER);
    check("no_payload", 12'h000, {11'h000, saw_data});
    with_data <= 1'b1;
    // Successful upgrade start leaves reduced mode
    do_reset;
    enter(2'h2);
    run_cmd(`SMMG_CMD_UPG_START);
    check("reload", 12'h001, {11'h000, saw_reload});
    check("exit", 12'h000, {10'h000, mode});
    conclude;
  end
endmodule
bind smmg_gate smmg_gate_asserts #(.AUTH_WIDTH(AUTH_WIDTH)) chk_inst (.clock, .rst_n, .legacy_set, .cmd_valid,
  .cmd_class, .cmd_ready, .dispatch, .rsp_valid, .rsp_code, .rsp_has_data, .data_path_enable,
  .status_path_enable, .internal_reset_n, .mode);
